// file: hdl/mff_pkg.sv
package mff_pkg;

    // address match memory geometry
    localparam int          MATCH_ENTRIES = 16;
    localparam int          MATCH_IDX_W   = 4;
    localparam int          MAC_ADDR_W    = 48;

    // register byte offsets on the bus
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_MATCH_SEL = 8'h04;
    localparam logic [7:0]  OFS_MATCH_LO  = 8'h08;
    localparam logic [7:0]  OFS_MATCH_HI  = 8'h0c;
    localparam logic [7:0]  OFS_MATCH_EN  = 8'h10;
    localparam logic [7:0]  OFS_RX_STAT   = 8'h14;
    localparam logic [7:0]  OFS_TX_STAT   = 8'h18;

    // control register fields
    localparam int          CTRL_W        = 6;
    localparam int          CTRL_PHYS     = 0;
    localparam int          CTRL_MULTI    = 1;
    localparam int          CTRL_BCAST    = 2;
    localparam int          CTRL_PROMISC  = 3;
    localparam int          CTRL_CRC_APP  = 4;
    localparam int          CTRL_RX_EN    = 5;
    localparam logic [5:0]  CTRL_RST      = 6'h10;

    // frame format
    localparam logic [5:0]  PRE_BITS      = 6'h3e;
    localparam logic [5:0]  HDR_BITS      = 6'h3f;
    localparam logic [5:0]  FCS_LAST      = 6'h1f;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [15:0] DA_END        = 16'h0006;
    localparam logic [15:0] SA_END        = 16'h000c;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // frame check sequence
    localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
    localparam logic [31:0] CRC_PRESET    = 32'hffffffff;
    localparam logic [31:0] CRC_RESIDUE   = 32'hc704dd7b;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} mff_tx_state_type;
    typedef enum logic {RX_HUNT, RX_DATA} mff_rx_state_type;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } mff_tx_byte_type;

    typedef struct packed {
        logic        bcast;
        logic        mcast;
        logic        accept;
        logic        crc_ok;
        logic [15:0] bytes;
    } mff_rx_status_type;

    typedef struct packed {
        logic crc_bad;
        logic monitored_bad_flag;
    } mff_tx_status_type;

    function automatic logic [31:0] mff_crc_step(input logic [31:0] c, input logic d);
        mff_crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ d) ? CRC_POLY : 32'h00000000);
    endfunction

endpackage

// file: hdl/mff_top.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - transmit 62 alternating preamble bits starting with one, before delimiter.
// - receive aligns bytes after two consecutive ones following the preamble.
// - destination first-byte lsb zero means individual (physical) address.
// - physical frames accepted only on full match with a stored entry, unless promiscuous.
// - first-byte lsb one means multicast; accepted only on exact entry match.
// - all-ones destination is broadcast, meant for every node.
// - promiscuous mode accepts every physical-address frame regardless of entries.
// - control register selects physical, multicast, broadcast, promiscuous acceptance.
// - while transmitting, check looped source address and looped frame CRC in the same cycle at frame end.
// - unmatched looped source address sets monitored bad flag in transmit status.
// - length/type field passes through untouched and drives no decision.
// - no padding; exactly the bytes offered are sent.
// - oversize received frames are neither rejected nor flagged.
// - frames up to 64k bytes pass both ways.
// - 32-bit CRC computed over the frame and appended on transmit.
// - CRC uses the standard 802.3 degree-32 generator polynomial.
// - CRC append is software selectable.
// - CRC checked on normal receive and on self-received transmit frames.
// - frame good when CRC register holds the fixed residue after last bit.
// - byte count of the whole received frame is reported.
// - preamble, delimiter and optional FCS are generated here, not by host.
// - preamble and delimiter stripped on receive; CRC bytes kept with frame.
// - link carries serial NRZ bits with bit clocks; no Manchester here.
module mff_top
    import mff_pkg::*;
(
    // clock and reset
    input  logic              REF_CLK_I,
    input  logic              RESET_I,
    // ahb-lite register slave
    input  logic              HSEL_I,
    input  logic [31:0]       HADDR_I,
    input  logic [1:0]        HTRANS_I,
    input  logic              HWRITE_I,
    input  logic [2:0]        HSIZE_I,
    input  logic [31:0]       HWDATA_I,
    input  logic              HREADY_I,
    output logic [31:0]       HRDATA_O,
    output logic              HREADYOUT_O,
    output logic              HRESP_O,
    // transmit byte stream
    input  mff_tx_byte_type   TX_BYTE_I,
    input  logic              TX_VALID_I,
    output logic              TX_READY_O,
    output logic              TX_BUSY_O,
    output logic              TX_DONE_O,
    output mff_tx_status_type TX_STATUS_O,
    // receive byte stream
    output logic [7:0]        RX_DATA_O,
    output logic              RX_VALID_O,
    output logic              RX_DONE_O,
    output mff_rx_status_type RX_STATUS_O,
    // line encoder/decoder link
    input  logic              LINK_TXC_I,
    output logic              LINK_TXD_O,
    output logic              LINK_TXEN_O,
    input  logic              LINK_RXC_I,
    input  logic              LINK_RXD_I,
    input  logic              LINK_CRS_I
);

    logic [2:0]              txc_s;
    logic [2:0]              rxc_s;
    logic [1:0]              rxd_s;
    logic [2:0]              crs_s;
    logic                    tx_edge;
    logic                    rx_edge;
    logic                    rx_bit;
    logic                    crs_fall;

    logic [CTRL_W-1:0]       ctrl_q;
    logic [MATCH_IDX_W-1:0]  match_sel_q;
    logic [MATCH_ENTRIES-1:0] match_en_q;
    logic [MAC_ADDR_W-1:0]   match_mem_q [MATCH_ENTRIES];
    logic                    ah_wr_q;
    logic [7:0]              ah_addr_q;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic                    ah_sel;

    mff_tx_state_type        tx_state_q;
    logic [5:0]              tx_cnt_q;
    logic [7:0]              tx_sh_q;
    logic                    tx_last_q;
    logic [31:0]             tx_crc_q;
    logic                    tx_txd_q;
    logic                    tx_txen_q;
    logic                    tx_start;
    logic                    tx_take;
    logic                    mon_q;

    mff_rx_state_type        rx_state_q;
    logic                    rx_prev_q;
    logic                    rx_pre_q;
    logic [2:0]              rx_bitc_q;
    logic [7:0]              rx_sh_q;
    logic [31:0]             rx_crc_q;
    logic [15:0]             rx_count_q;
    logic [MAC_ADDR_W-1:0]   rx_da_q;
    logic [MAC_ADDR_W-1:0]   rx_sa_q;
    logic [7:0]              rx_data_q;
    logic                    rx_valid_q;
    logic                    rx_end;
    logic [7:0]              rx_byte;

    logic [MATCH_ENTRIES-1:0] da_hit_v;
    logic [MATCH_ENTRIES-1:0] sa_hit_v;
    logic                    da_bcast;
    logic                    da_mcast;
    logic                    rx_accept;

    mff_rx_status_type       rx_stat_q;
    mff_tx_status_type       tx_stat_q;
    logic                    rx_done_q;
    logic                    tx_done_q;

    // link pins come from the bit clocks' domains; only stage two onward is read
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            txc_s <= 3'h0;
            rxc_s <= 3'h0;
            rxd_s <= 2'h0;
            crs_s <= 3'h0;
        end else begin
            txc_s <= {txc_s[1:0], LINK_TXC_I};
            rxc_s <= {rxc_s[1:0], LINK_RXC_I};
            rxd_s <= {rxd_s[0], LINK_RXD_I};
            crs_s <= {crs_s[1:0], LINK_CRS_I};
        end
    end

    assign tx_edge  = txc_s[1] & ~txc_s[2];
    assign rx_edge  = rxc_s[1] & ~rxc_s[2];
    assign rx_bit   = rxd_s[1];
    assign crs_fall = ~crs_s[1] & crs_s[2];

    // ---------------- register slave ----------------
    assign ah_sel      = HSEL_I & (HTRANS_I == HTRANS_NONSEQ) & HREADY_I;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = rdata_q;

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            ah_wr_q   <= 1'b0;
            ah_addr_q <= 8'h00;
            rdata_q   <= 32'h00000000;
        end else begin
            ah_wr_q   <= ah_sel & HWRITE_I;
            ah_addr_q <= HADDR_I[7:0];
            if (ah_sel & ~HWRITE_I) begin
                rdata_q <= rdata_d;
            end
        end
    end

    always_comb begin
        case (HADDR_I[7:0])
            OFS_CTRL:      rdata_d = {26'h0000000, ctrl_q};
            OFS_MATCH_SEL: rdata_d = {28'h0000000, match_sel_q};
            OFS_MATCH_LO:  rdata_d = match_mem_q[match_sel_q][31:0];
            OFS_MATCH_HI:  rdata_d = {16'h0000, match_mem_q[match_sel_q][47:32]};
            OFS_MATCH_EN:  rdata_d = {16'h0000, match_en_q};
            OFS_RX_STAT:   rdata_d = {12'h000, rx_stat_q};
            OFS_TX_STAT:   rdata_d = {30'h00000000, tx_stat_q};
            default:       rdata_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            ctrl_q      <= CTRL_RST;
            match_sel_q <= '0;
            match_en_q  <= '0;
        end else if (ah_wr_q) begin
            case (ah_addr_q)
                OFS_CTRL:      ctrl_q      <= HWDATA_I[CTRL_W-1:0];
                OFS_MATCH_SEL: match_sel_q <= HWDATA_I[MATCH_IDX_W-1:0];
                OFS_MATCH_EN:  match_en_q  <= HWDATA_I[MATCH_ENTRIES-1:0];
                default: ;
            endcase
        end
    end

    // entries hold the first address byte in bits 7:0
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            for (int i = 0; i < MATCH_ENTRIES; i++) begin
                match_mem_q[i] <= '0;
            end
        end else if (ah_wr_q && ah_addr_q == OFS_MATCH_LO) begin
            match_mem_q[match_sel_q][31:0] <= HWDATA_I;
        end else if (ah_wr_q && ah_addr_q == OFS_MATCH_HI) begin
            match_mem_q[match_sel_q][47:32] <= HWDATA_I[15:0];
        end
    end

    // ---------------- address matching ----------------
    for (genvar i = 0; i < MATCH_ENTRIES; i++) begin : g_match
        assign da_hit_v[i] = match_en_q[i] & (match_mem_q[i] == rx_da_q);
        assign sa_hit_v[i] = match_en_q[i] & (match_mem_q[i] == rx_sa_q);
    end

    assign da_bcast = &rx_da_q;
    assign da_mcast = rx_da_q[0] & ~da_bcast;
    // a broadcast also has lsb one, so it is kept out of the multicast branch
    assign rx_accept = ctrl_q[CTRL_RX_EN] & (
        (da_bcast & ctrl_q[CTRL_BCAST]) |
        (~rx_da_q[0] & (ctrl_q[CTRL_PROMISC] | (ctrl_q[CTRL_PHYS] & |da_hit_v))) |
        (da_mcast & ctrl_q[CTRL_MULTI] & |da_hit_v));

    // ---------------- transmit ----------------
    assign tx_start   = tx_edge & (tx_state_q == TX_IDLE) & TX_VALID_I;
    assign tx_take    = tx_edge & (tx_state_q == TX_DATA) & (tx_cnt_q[2:0] == 3'h0) & TX_VALID_I;
    assign TX_READY_O = tx_take;
    assign TX_BUSY_O  = (tx_state_q != TX_IDLE) | mon_q;
    assign LINK_TXD_O  = tx_txd_q;
    assign LINK_TXEN_O = tx_txen_q;

    // the delimiter is the last two counts of the header, both ones
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            tx_state_q <= TX_IDLE;
            tx_cnt_q   <= 6'h00;
            tx_sh_q    <= 8'h00;
            tx_last_q  <= 1'b0;
            tx_crc_q   <= CRC_PRESET;
            tx_txd_q   <= 1'b0;
            tx_txen_q  <= 1'b0;
        end else if (tx_edge) begin
            case (tx_state_q)
                TX_IDLE: begin
                    tx_txen_q <= 1'b0;
                    tx_txd_q  <= 1'b0;
                    if (TX_VALID_I) begin
                        tx_state_q <= TX_PRE;
                        tx_txen_q  <= 1'b1;
                        tx_txd_q   <= 1'b1;
                        tx_cnt_q   <= 6'h01;
                    end
                end
                TX_PRE: begin
                    tx_txd_q <= (tx_cnt_q >= PRE_BITS) | ~tx_cnt_q[0];
                    tx_cnt_q <= tx_cnt_q + 6'h01;
                    if (tx_cnt_q == HDR_BITS) begin
                        tx_state_q <= TX_DATA;
                        tx_cnt_q   <= 6'h00;
                        tx_crc_q   <= CRC_PRESET;
                    end
                end
                TX_DATA: begin
                    tx_cnt_q <= {3'h0, tx_cnt_q[2:0] + 3'h1};
                    if (tx_cnt_q[2:0] == 3'h0) begin
                        if (TX_VALID_I) begin
                            tx_txd_q  <= TX_BYTE_I.data[0];
                            tx_sh_q   <= TX_BYTE_I.data;
                            tx_last_q <= TX_BYTE_I.last;
                            tx_crc_q  <= mff_crc_step(tx_crc_q, TX_BYTE_I.data[0]);
                        end else begin
                            // underrun aborts the frame without an FCS
                            tx_state_q <= TX_IDLE;
                            tx_txen_q  <= 1'b0;
                            tx_txd_q   <= 1'b0;
                            tx_cnt_q   <= 6'h00;
                        end
                    end else begin
                        tx_txd_q <= tx_sh_q[tx_cnt_q[2:0]];
                        tx_crc_q <= mff_crc_step(tx_crc_q, tx_sh_q[tx_cnt_q[2:0]]);
                        if (tx_cnt_q[2:0] == BIT_LAST && tx_last_q) begin
                            tx_cnt_q   <= 6'h00;
                            tx_state_q <= ctrl_q[CTRL_CRC_APP] ? TX_FCS : TX_IDLE;
                        end
                    end
                end
                TX_FCS: begin
                    tx_txd_q <= ~tx_crc_q[31];
                    tx_crc_q <= {tx_crc_q[30:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q + 6'h01;
                    if (tx_cnt_q == FCS_LAST) begin
                        tx_state_q <= TX_IDLE;
                        tx_cnt_q   <= 6'h00;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // self-receive of our own frame is monitored, never delivered
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            mon_q <= 1'b0;
        end else if (tx_start) begin
            mon_q <= 1'b1;
        end else if (rx_end && tx_state_q == TX_IDLE) begin
            mon_q <= 1'b0;
        end
    end

    // ---------------- receive ----------------
    assign rx_end  = crs_fall & (rx_state_q == RX_DATA);
    assign rx_byte = {rx_bit, rx_sh_q[7:1]};
    assign RX_DATA_O  = rx_data_q;
    assign RX_VALID_O = rx_valid_q;

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            rx_state_q <= RX_HUNT;
            rx_prev_q  <= 1'b0;
            rx_pre_q   <= 1'b0;
            rx_bitc_q  <= 3'h0;
            rx_sh_q    <= 8'h00;
            rx_crc_q   <= CRC_PRESET;
            rx_count_q <= 16'h0000;
            rx_da_q    <= '0;
            rx_sa_q    <= '0;
            rx_data_q  <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (crs_fall) begin
                rx_state_q <= RX_HUNT;
                rx_prev_q  <= 1'b0;
                rx_pre_q   <= 1'b0;
            end else if (rx_edge && crs_s[1]) begin
                case (rx_state_q)
                    RX_HUNT: begin
                        rx_prev_q <= rx_bit;
                        if (rx_prev_q && !rx_bit) begin
                            rx_pre_q <= 1'b1;
                        end
                        if (rx_prev_q && rx_bit && rx_pre_q) begin
                            rx_state_q <= RX_DATA;
                            rx_bitc_q  <= 3'h0;
                            rx_crc_q   <= CRC_PRESET;
                            rx_count_q <= 16'h0000;
                            rx_da_q    <= '0;
                            rx_sa_q    <= '0;
                        end
                    end
                    RX_DATA: begin
                        rx_sh_q   <= rx_byte;
                        rx_crc_q  <= mff_crc_step(rx_crc_q, rx_bit);
                        rx_bitc_q <= rx_bitc_q + 3'h1;
                        if (rx_bitc_q == BIT_LAST) begin
                            rx_data_q  <= rx_byte;
                            rx_valid_q <= ~mon_q & ctrl_q[CTRL_RX_EN];
                            // count saturates instead of flagging oversize
                            if (rx_count_q != COUNT_MAX) begin
                                rx_count_q <= rx_count_q + 16'h0001;
                            end
                            if (rx_count_q < DA_END) begin
                                rx_da_q <= {rx_byte, rx_da_q[47:8]};
                            end else if (rx_count_q < SA_END) begin
                                rx_sa_q <= {rx_byte, rx_sa_q[47:8]};
                            end
                        end
                    end
                    default: rx_state_q <= RX_HUNT;
                endcase
            end
        end
    end

    // frame end: looped frames report to transmit status, others to receive status
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            rx_stat_q <= '0;
            tx_stat_q <= '0;
            rx_done_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            tx_done_q <= 1'b0;
            if (rx_end && mon_q) begin
                tx_stat_q.monitored_bad_flag <= ~|sa_hit_v;
                tx_stat_q.crc_bad <= (rx_crc_q != CRC_RESIDUE);
                tx_done_q <= 1'b1;
            end else if (rx_end) begin
                rx_stat_q.bytes  <= rx_count_q;
                rx_stat_q.crc_ok <= (rx_crc_q == CRC_RESIDUE);
                rx_stat_q.accept <= rx_accept;
                rx_stat_q.mcast  <= da_mcast;
                rx_stat_q.bcast  <= da_bcast;
                rx_done_q <= ctrl_q[CTRL_RX_EN];
            end
        end
    end

    assign RX_DONE_O   = rx_done_q;
    assign RX_STATUS_O = rx_stat_q;
    assign TX_DONE_O   = tx_done_q;
    assign TX_STATUS_O = tx_stat_q;

endmodule // mff_top

// file: sim/mff_line_model.sv
`timescale 1ns/1ps
module mff_line_model (
    // from the block
    input  wire logic txd_i,
    input  wire logic txen_i,
    // to the block
    output logic      txc_o,
    output logic      rxc_o,
    output logic      rxd_o,
    output logic      crs_o
);
    logic crs_q = 1'b0;
    logic gen_q = 1'b0;
    logic rxc_q = 1'b0;
    logic rxd_q = 1'b0;
    initial txc_o = 1'b0;
    // transmit clock runs free so a frame may start at any bit time
    always #200 txc_o = ~txc_o;
    always @(negedge txc_o) crs_q <= txen_i;
    // looped clock stands still outside carrier; idle data shows the inverse
    assign rxc_o = gen_q ? rxc_q : (txc_o & crs_q);
    assign crs_o = gen_q | crs_q;
    assign rxd_o = gen_q ? rxd_q : (crs_q ? txd_i : ~txd_i);
    task automatic send(input logic b[$]);
        gen_q = 1'b1;
        foreach (b[i]) begin
            rxd_q = b[i];
            #200 rxc_q = 1'b1;
            #200 rxc_q = 1'b0;
        end
        rxd_q = ~rxd_q;
        #200 gen_q = 1'b0;
    endtask
endmodule // mff_line_model

// file: sim/mff_props.sv
`timescale 1ns/1ps
module mff_props
    import mff_pkg::*;
(
    // clock and reset
    input logic              REF_CLK_I,
    input logic              RESET_I,
    // register bus
    input logic              HSEL_I,
    input logic [31:0]       HADDR_I,
    input logic [1:0]        HTRANS_I,
    input logic              HWRITE_I,
    input logic              HREADY_I,
    input logic [31:0]       HRDATA_O,
    input logic              HREADYOUT_O,
    input logic              HRESP_O,
    // streams
    input logic              TX_VALID_I,
    input logic              TX_READY_O,
    input logic              TX_BUSY_O,
    input logic              TX_DONE_O,
    input logic              RX_VALID_O,
    input logic              RX_DONE_O,
    input mff_rx_status_type RX_STATUS_O,
    // link
    input logic              LINK_TXC_I,
    input logic              LINK_TXD_O,
    input logic              LINK_TXEN_O,
    input logic              LINK_CRS_I
);
    logic       txc_q;
    logic [19:0] bit_n_q;
    // raw bit clock rises; wide enough for a 64k byte frame so the byte phase never saturates
    always_ff @(posedge REF_CLK_I) txc_q <= LINK_TXC_I;
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || !LINK_TXEN_O) bit_n_q <= 20'h00000;
        else if (LINK_TXC_I && !txc_q) bit_n_q <= bit_n_q + 20'h00001;
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus slave not ready or not okay");
    unmapped_zero_a: assert property (HSEL_I && HTRANS_I == HTRANS_NONSEQ && HREADY_I &&
        !HWRITE_I && HADDR_I[7:0] == 8'h1c |=> HRDATA_O == 32'h0)
        else $error("unmapped read returned data");
    preamble_first_a: assert property ($rose(LINK_TXEN_O) |-> LINK_TXD_O)
        else $error("frame did not open with a one");
    header_len_a: assert property (TX_READY_O && bit_n_q < 20'h00041 |-> bit_n_q == 20'h00040)
        else $error("first byte not taken after the header bits");
    byte_pace_a: assert property (TX_READY_O |-> bit_n_q[2:0] == 3'h0 && TX_VALID_I && LINK_TXEN_O)
        else $error("byte taken off its bit slot");
    self_quiet_a: assert property (TX_BUSY_O |-> !RX_VALID_O && !RX_DONE_O)
        else $error("self received frame reached the receive stream");
    tx_done_a: assert property (TX_DONE_O |-> !LINK_TXEN_O ##1 !TX_DONE_O)
        else $error("transmit done while sending or held");
    frame_end_a: assert property ($fell(LINK_CRS_I) |-> ##[1:8] (RX_DONE_O || TX_DONE_O))
        else $error("no completion after carrier drop");
    status_hold_a: assert property (!RX_DONE_O && !TX_DONE_O |-> $stable(RX_STATUS_O))
        else $error("receive status changed between frames");
    rx_byte_a: assert property (RX_VALID_O |=> !RX_VALID_O)
        else $error("received byte strobe too long");
endmodule // mff_props
bind mff_top mff_props i_mff_props (.*);

// file: sim/mff_top_bench.sv
`timescale 1ns/1ps
module mff_top_bench;
    import mff_pkg::*;
    localparam logic [47:0] AD [4] = '{48'h050403020102, 48'h050403020103,
                                       48'h0a0b0c0d0e04, 48'hffffffffffff};
    localparam int          DI [8] = '{0, 2, 2, 1, 3, 3, 0, 0};
    localparam logic [5:0]  RC [8] = '{6'h37, 6'h37, 6'h3f, 6'h37, 6'h37, 6'h33, 6'h36, 6'h37};
    localparam logic [7:0]  AC     = 8'h9d;
    logic              REF_CLK_I  = 1'b0;
    logic              RESET_I    = 1'b1;
    logic              HSEL_I     = 1'b0;
    logic              HWRITE_I   = 1'b0;
    logic [1:0]        HTRANS_I   = 2'h0;
    logic [2:0]        HSIZE_I    = 3'h2;
    logic [31:0]       HADDR_I    = 32'h0;
    logic [31:0]       HWDATA_I   = 32'h0;
    mff_tx_byte_type   TX_BYTE_I  = '0;
    logic              TX_VALID_I = 1'b0;
    logic              HREADY_I, HREADYOUT_O, HRESP_O, TX_READY_O, TX_BUSY_O, TX_DONE_O;
    logic              RX_VALID_O, RX_DONE_O, LINK_TXC_I, LINK_TXD_O, LINK_TXEN_O;
    logic              LINK_RXC_I, LINK_RXD_I, LINK_CRS_I;
    logic [31:0]       HRDATA_O, rd;
    logic [7:0]        RX_DATA_O;
    mff_tx_status_type TX_STATUS_O;
    mff_rx_status_type RX_STATUS_O;
    logic [7:0]        fr[$], rxq[$];
    logic              bits[$], txq[$];
    int                mismatches  = 0;
    int                comparisons = 0;
    always #25 REF_CLK_I = ~REF_CLK_I;
    assign HREADY_I = HREADYOUT_O;
    mff_top i_mff_top (.*);
    mff_line_model i_mff_line_model (.txd_i(LINK_TXD_O), .txen_i(LINK_TXEN_O),
        .txc_o(LINK_TXC_I), .rxc_o(LINK_RXC_I), .rxd_o(LINK_RXD_I), .crs_o(LINK_CRS_I));
    always @(negedge REF_CLK_I) if (RX_VALID_O === 1'b1) rxq.push_back(RX_DATA_O);
    always @(posedge LINK_TXC_I) if (LINK_TXEN_O === 1'b1) txq.push_back(LINK_TXD_O);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic hold;
        logic r;
        do begin
            @(negedge REF_CLK_I);
            r = HREADYOUT_O;
            rd = HRDATA_O;
            @(posedge REF_CLK_I);
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK_I);
        HSEL_I <= 1'b1;
        HTRANS_I <= HTRANS_NONSEQ;
        HADDR_I <= {24'h0, a};
        HWRITE_I <= w;
        hold();
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= d;
        hold();
    endtask
    // frame of 64 bytes with its own check sequence; host pads and supplies the source
    task automatic mk(input logic [47:0] da, input logic [47:0] sa, input logic bad);
        logic [31:0] c;
        logic [7:0]  b;
        fr = {};
        bits = {};
        c = 32'hffffffff;
        for (int i = 0; i < 6; i++) fr.push_back(da[8*i+:8]);
        for (int i = 0; i < 6; i++) fr.push_back(sa[8*i+:8]);
        fr.push_back(8'h00);
        fr.push_back(8'h2e);
        for (int i = 0; i < 46; i++) fr.push_back(8'(i));
        foreach (fr[i])
            for (int j = 0; j < 8; j++)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ fr[i][j]) ? 32'h04c11db7 : 32'h0);
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 8; j++) b[j] = ~c[31-8*k-j];
            fr.push_back(b);
        end
        fr[63] = fr[63] ^ {7'h0, bad};
        for (int i = 0; i < 62; i++) bits.push_back(i % 2 == 0);
        bits.push_back(1'b1);
        bits.push_back(1'b1);
        foreach (fr[i]) for (int j = 0; j < 8; j++) bits.push_back(fr[i][j]);
    endtask
    task automatic tx(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            TX_BYTE_I <= '{last: (i == n - 1), data: fr[i]};
            TX_VALID_I <= 1'b1;
            do begin
                @(negedge REF_CLK_I);
                r = TX_READY_O;
                @(posedge REF_CLK_I);
            end while (r !== 1'b1);
        end
        TX_VALID_I <= 1'b0;
    endtask
    task automatic pulse(input logic tx_side);
        int n;
        n = 0;
        do begin
            @(negedge REF_CLK_I);
            n++;
        end while ((tx_side ? TX_DONE_O : RX_DONE_O) !== 1'b1 && n < 20000);
        chk(32'(n < 20000), 32'h1);
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK_I);
        RESET_I <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h10);
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, OFS_MATCH_SEL, 32'(i));
            bus(1'b1, OFS_MATCH_LO, AD[i][31:0]);
            bus(1'b1, OFS_MATCH_HI, {16'h0, AD[i][47:32]});
        end
        // third entry stays disabled so its address must not match
        bus(1'b1, OFS_MATCH_EN, 32'h3);
        foreach (RC[k]) begin
            bus(1'b1, OFS_CTRL, {26'h0, RC[k]});
            mk(AD[DI[k]], AD[0], k == 7);
            rxq = {};
            i_mff_line_model.send(bits);
            pulse(1'b0);
            chk(RX_STATUS_O.bytes, 32'h40);
            chk(RX_STATUS_O.crc_ok, k != 7);
            if (k != 7) chk(RX_STATUS_O.accept, AC[k]);
            chk(RX_STATUS_O.bcast, DI[k] == 3);
            if (DI[k] != 3) chk(RX_STATUS_O.mcast, AD[DI[k]][0]);
            foreach (fr[i]) chk(rxq[i], fr[i]);
        end
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, OFS_CTRL, k == 2 ? 32'h27 : 32'h37);
            mk(AD[2], AD[k == 1 ? 2 : 0], 1'b0);
            txq = {};
            rxq = {};
            tx(k == 2 ? 64 : 60);
            pulse(1'b1);
            chk(TX_STATUS_O, {1'b0, k == 1});
            chk(txq.size(), bits.size());
            foreach (bits[i]) chk(txq[i], bits[i]);
            chk(rxq.size(), 32'h0);
            bus(1'b0, OFS_TX_STAT, 32'h0);
            chk(rd, {31'h0, k == 1});
        end
        wrap_up();
    end
    initial begin
        repeat (90000) @(posedge REF_CLK_I);
        mismatches++;
        wrap_up();
    end
endmodule // mff_top_bench
